// file: common/cos_pkg.sv
// Functional notes
// RQ1: Square wave enable high selects square wave; low selects general purpose output.
// RQ2: On backup supply the pin is released in both modes.
// RQ3: Select 00 divides the oscillator by 32768; select 01 divides by 8.
// RQ4: Select 10 divides by 4; select 11 passes the oscillator undivided.
// RQ5: Divided rates count trimmed ticks; the undivided rate bypasses trimming.
// RQ6: In general purpose mode the pin follows the output level bit only.
// RQ7: Coarse trim forces trimmed 1 Hz output and ignores the select bits.
// RQ8: External oscillator bit takes timing from the crystal input pin instead.
// RQ9: Output level 0 drives low, 1 drives high; ignored in square wave mode.
// RQ10: Divided wave is near 50 percent duty; select changes act without reset.
package cos_pkg;

  // Control register location and reset value
  localparam logic [7:0] CTRL_ADDR  = 8'h08;
  localparam logic [7:0] CTRL_RESET = 8'h80;

  // Control register field positions
  localparam int BIT_OUT_LEVEL   = 7;
  localparam int BIT_SQW_EN      = 6;
  localparam int BIT_ALARM_ONE   = 5;
  localparam int BIT_ALARM_ZERO  = 4;
  localparam int BIT_EXT_OSC     = 3;
  localparam int BIT_COARSE_TRIM = 2;
  localparam int BIT_FSEL_HI     = 1;
  localparam int BIT_FSEL_LO     = 0;

  // Frequency select codes
  localparam logic [1:0] FSEL_1HZ   = 2'h0;
  localparam logic [1:0] FSEL_4K    = 2'h1;
  localparam logic [1:0] FSEL_8K    = 2'h2;
  localparam logic [1:0] FSEL_32K   = 2'h3;

  // Postscaler ratios and half periods in oscillator ticks
  localparam int OSC_HZ  = 32768;
  localparam int DIV_1HZ = 32768;
  localparam int DIV_4K  = 8;
  localparam int DIV_8K  = 4;
  localparam int HALF_W  = 15;
  localparam logic [HALF_W-1:0] HALF_1HZ = HALF_W'(DIV_1HZ / 2);
  localparam logic [HALF_W-1:0] HALF_4K  = HALF_W'(DIV_4K / 2);
  localparam logic [HALF_W-1:0] HALF_8K  = HALF_W'(DIV_8K / 2);

  // System clock
  localparam int CLK_HZ = 100000000;

endpackage

// file: design/cos_postscaler.sv
`timescale 1ns/1ns
module cos_postscaler #(
  parameter int HALF_W = cos_pkg::HALF_W
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Tick and ratio
  input  wire logic              tick_en,
  input  wire logic [HALF_W-1:0] half_count,
  // Divided wave
  output logic                   wave
);

  logic [HALF_W-1:0] cnt_reg;
  logic [HALF_W-1:0] cnt_next;
  logic              wave_reg;
  logic              wave_next;

  // Compare with >= so a shorter ratio written mid-count wraps at once
  always_comb begin
    cnt_next  = cnt_reg;
    wave_next = wave_reg;
    if (tick_en) begin
      if (cnt_reg >= half_count - HALF_W'(1)) begin // [RQ10]
        cnt_next  = '0;
        wave_next = ~wave_reg;                      // [RQ10]
      end else begin
        cnt_next = cnt_reg + HALF_W'(1);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg  <= '0;
      wave_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      wave_reg <= wave_next;
    end
  end

  assign wave = wave_reg;

endmodule

// file: design/cos_clock_output_selector.sv
`timescale 1ns/1ns
module cos_clock_output_selector (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Control register port
  input  wire logic       ctrl_wr_en,
  input  wire logic       ctrl_rd_en,
  input  wire logic [7:0] ctrl_addr,
  input  wire logic [7:0] ctrl_wdata,
  output logic      [7:0] ctrl_rdata,
  // Oscillator sources, asynchronous pins
  input  wire logic       crystal_osc_in,
  input  wire logic       crystal_input_pin,
  input  wire logic       oscillator_start_bit,
  // Supply state, asynchronous
  input  wire logic       on_backup_supply,
  // Trim unit requests, one-cycle pulses on clk
  input  wire logic       trim_swallow,
  input  wire logic       trim_insert,
  // Clock output pin
  output logic            clock_out_pin,
  output logic            clock_out_oe_n,
  // Control bits and oscillator tick used elsewhere
  output logic            alarm_one_enable,
  output logic            alarm_zero_enable,
  output logic            external_osc_input,
  output logic            osc_tick
);

  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  logic       xtal_s1_reg;
  logic       xtal_s2_reg;
  logic       ext_s1_reg;
  logic       ext_s2_reg;
  logic       bkp_s1_reg;
  logic       bkp_s2_reg;
  logic       st_s1_reg;
  logic       st_s2_reg;
  logic       xtal_s1_next;
  logic       xtal_s2_next;
  logic       ext_s1_next;
  logic       ext_s2_next;
  logic       bkp_s1_next;
  logic       bkp_s2_next;
  logic       st_s1_next;
  logic       st_s2_next;

  logic       osc_prev_reg;
  logic       osc_prev_next;
  logic       tick_reg;
  logic       tick_next;

  logic       pin_reg;
  logic       pin_next;
  logic       oe_n_reg;
  logic       oe_n_next;

  logic       osc_level;
  logic       trimmed_tick;
  logic       divided_wave;
  logic       square_wave_enable;
  logic       coarse_trim_enable;
  logic       out_level;
  logic [1:0] square_freq_select;
  logic [cos_pkg::HALF_W-1:0] half_count;

  assign square_wave_enable = ctrl_reg[cos_pkg::BIT_SQW_EN];
  assign coarse_trim_enable = ctrl_reg[cos_pkg::BIT_COARSE_TRIM];
  assign out_level          = ctrl_reg[cos_pkg::BIT_OUT_LEVEL];
  assign square_freq_select = ctrl_reg[cos_pkg::BIT_FSEL_HI:cos_pkg::BIT_FSEL_LO];

  // Control register write and readback
  always_comb begin
    ctrl_next  = ctrl_reg;
    rdata_next = rdata_reg;
    if (ctrl_wr_en && ctrl_addr == cos_pkg::CTRL_ADDR) begin
      ctrl_next = ctrl_wdata;
    end
    if (ctrl_rd_en) begin
      // Unmapped reads answer zero
      rdata_next = (ctrl_addr == cos_pkg::CTRL_ADDR) ? ctrl_reg : 8'h00;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_reg  <= cos_pkg::CTRL_RESET;
      rdata_reg <= 8'h00;
    end else begin
      ctrl_reg  <= ctrl_next;
      rdata_reg <= rdata_next;
    end
  end

  // Two-flop synchronisers for everything from outside the clock domain
  always_comb begin
    xtal_s1_next = crystal_osc_in;
    xtal_s2_next = xtal_s1_reg;
    ext_s1_next  = crystal_input_pin;
    ext_s2_next  = ext_s1_reg;
    bkp_s1_next  = on_backup_supply;
    bkp_s2_next  = bkp_s1_reg;
    st_s1_next   = oscillator_start_bit;
    st_s2_next   = st_s1_reg;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      xtal_s1_reg <= 1'b0;
      xtal_s2_reg <= 1'b0;
      ext_s1_reg  <= 1'b0;
      ext_s2_reg  <= 1'b0;
      bkp_s1_reg  <= 1'b0;
      bkp_s2_reg  <= 1'b0;
      st_s1_reg   <= 1'b0;
      st_s2_reg   <= 1'b0;
    end else begin
      xtal_s1_reg <= xtal_s1_next;
      xtal_s2_reg <= xtal_s2_next;
      ext_s1_reg  <= ext_s1_next;
      ext_s2_reg  <= ext_s2_next;
      bkp_s1_reg  <= bkp_s1_next;
      bkp_s2_reg  <= bkp_s2_next;
      st_s1_reg   <= st_s1_next;
      st_s2_reg   <= st_s2_next;
    end
  end

  // Source select; a stopped crystal gives no ticks at all
  always_comb begin
    if (ctrl_reg[cos_pkg::BIT_EXT_OSC]) begin
      osc_level = ext_s2_reg;                 // [RQ8]
    end else begin
      osc_level = xtal_s2_reg & st_s2_reg;
    end
  end

  // Rising edge of the chosen oscillator is one tick
  always_comb begin
    osc_prev_next = osc_level;
    tick_next     = osc_level & ~osc_prev_reg;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      osc_prev_reg <= 1'b0;
      tick_reg     <= 1'b0;
    end else begin
      osc_prev_reg <= osc_prev_next;
      tick_reg     <= tick_next;
    end
  end

  // Trim unit may drop or add a tick; divided rates see the result
  assign trimmed_tick = (tick_reg & ~trim_swallow) | trim_insert; // [RQ5]

  // Ratio select; coarse trim overrides the select bits
  always_comb begin
    half_count = cos_pkg::HALF_1HZ;
    if (coarse_trim_enable) begin
      half_count = cos_pkg::HALF_1HZ;                            // [RQ7]
    end else begin
      unique case (square_freq_select)
        cos_pkg::FSEL_1HZ: half_count = cos_pkg::HALF_1HZ;       // [RQ3]
        cos_pkg::FSEL_4K:  half_count = cos_pkg::HALF_4K;        // [RQ3]
        cos_pkg::FSEL_8K:  half_count = cos_pkg::HALF_8K;        // [RQ4]
        cos_pkg::FSEL_32K: half_count = cos_pkg::HALF_1HZ;
      endcase
    end
  end

  cos_postscaler #(
    .HALF_W(cos_pkg::HALF_W)
  ) u_postscaler (
    .clk        (clk),
    .rst        (rst),
    .tick_en    (trimmed_tick),
    .half_count (half_count),
    .wave       (divided_wave)
  );

  // Output pin mux; released on backup so nothing loads the battery
  always_comb begin
    pin_next  = 1'b0;
    oe_n_next = 1'b1;
    if (bkp_s2_reg) begin
      pin_next  = 1'b0;                                          // [RQ2]
      oe_n_next = 1'b1;                                          // [RQ2]
    end else if (square_wave_enable) begin                       // [RQ1]
      oe_n_next = 1'b0;
      if (!coarse_trim_enable && square_freq_select == cos_pkg::FSEL_32K) begin
        pin_next = osc_prev_reg;                                 // [RQ4] [RQ5]
      end else begin
        pin_next = divided_wave;                                 // [RQ7] [RQ9]
      end
    end else begin
      oe_n_next = 1'b0;
      pin_next  = out_level;                                     // [RQ6] [RQ9]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_reg  <= 1'b0;
      oe_n_reg <= 1'b1;
    end else begin
      pin_reg  <= pin_next;
      oe_n_reg <= oe_n_next;
    end
  end

  assign clock_out_pin      = pin_reg;
  assign clock_out_oe_n     = oe_n_reg;
  assign ctrl_rdata         = rdata_reg;
  assign alarm_one_enable   = ctrl_reg[cos_pkg::BIT_ALARM_ONE];
  assign alarm_zero_enable  = ctrl_reg[cos_pkg::BIT_ALARM_ZERO];
  assign external_osc_input = ctrl_reg[cos_pkg::BIT_EXT_OSC];
  assign osc_tick           = tick_reg;

endmodule

// file: tb/cos_checker_asserts.sv
`timescale 1ns/1ns
module cos_checker (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // Register port
  input wire logic       ctrl_wr_en,
  input wire logic       ctrl_rd_en,
  input wire logic [7:0] ctrl_addr,
  input wire logic [7:0] ctrl_wdata,
  input wire logic [7:0] ctrl_rdata,
  // Supply and pin
  input wire logic       on_backup_supply,
  input wire logic       clock_out_pin,
  input wire logic       clock_out_oe_n,
  // Control bits
  input wire logic       alarm_one_enable,
  input wire logic       alarm_zero_enable,
  input wire logic       external_osc_input,
  // Oscillator tick
  input wire logic       osc_tick
);
  logic [7:0] sh_reg, sh_next;
  logic [1:0] age_reg, age_next;
  // Shadow of the register; age hides the two-cycle pin latency
  always_comb begin
    sh_next  = sh_reg;
    age_next = (age_reg == 2'h3) ? age_reg : age_reg + 2'h1;
    if (ctrl_wr_en && ctrl_addr == cos_pkg::CTRL_ADDR) begin
      sh_next  = ctrl_wdata;
      age_next = 2'h0;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sh_reg  <= cos_pkg::CTRL_RESET;
      age_reg <= 2'h0;
    end else begin
      sh_reg  <= sh_next;
      age_reg <= age_next;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_backup_off: assert property (on_backup_supply [*4] |-> clock_out_oe_n)
    else $error("pin not released on backup");
  a_power_back: assert property (!on_backup_supply [*4] |-> !clock_out_oe_n)
    else $error("pin not driven on main supply");
  a_release_low: assert property (clock_out_oe_n |-> !clock_out_pin)
    else $error("released pin not low");
  a_gpo_level: assert property (!clock_out_oe_n && !sh_reg[6] && age_reg >= 2'h2
    |-> clock_out_pin == sh_reg[7]) else $error("pin level differs from output bit");
  a_rd_value: assert property (ctrl_rd_en && ctrl_addr == 8'h08
    |=> ctrl_rdata == $past(sh_reg)) else $error("read data differs");
  a_rd_unmapped: assert property (ctrl_rd_en && ctrl_addr != 8'h08 |=> ctrl_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rd_hold: assert property (!ctrl_rd_en |=> $stable(ctrl_rdata))
    else $error("read data changed without read");
  a_ctrl_bits: assert property ({alarm_one_enable, alarm_zero_enable,
    external_osc_input} == sh_reg[5:3]) else $error("control outputs differ");
  a_tick_pulse: assert property (osc_tick |=> !osc_tick)
    else $error("oscillator tick longer than one cycle");
  c_square: cover property (sh_reg[6] && $rose(clock_out_pin));
  c_backup: cover property (on_backup_supply && clock_out_oe_n);
  c_unmapped: cover property (ctrl_rd_en && ctrl_addr != 8'h08);
endmodule
bind cos_clock_output_selector cos_checker u_chk (.clk, .rst, .ctrl_wr_en, .ctrl_rd_en,
  .ctrl_addr, .ctrl_wdata, .ctrl_rdata, .on_backup_supply, .clock_out_pin,
  .clock_out_oe_n, .alarm_one_enable, .alarm_zero_enable, .external_osc_input, .osc_tick);

// file: tb/cos_pin_load.sv
`timescale 1ns/1ns
module cos_pin_load (
  // Pin from the block
  input wire logic clock_out_pin,
  input wire logic clock_out_oe_n,
  // Observed line
  output logic     line_level,
  output int       rise_count
);
  // Pull-down holds the line low once the pin is released
  assign line_level = clock_out_oe_n ? 1'b0 : clock_out_pin;
  initial rise_count = 0;
  always @(posedge line_level) rise_count++;
endmodule

// file: tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic       clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic       ph = 1'b0, xi_run = 1'b0, st = 1'b1, bk = 1'b0, sw = 1'b0, ins = 1'b0;
  logic       pin, oe_n, a1, a0, ext, line, otk;
  int         fails = 0, n_compared = 0, rises, ticks = 0;
  // Both sources share one 80 ns phase, toggling on falling clock edges, off the rising ones
  always #5 clk = ~clk;
  always #40 ph = ~ph;
  cos_clock_output_selector u_dut (.clk(clk), .rst(rst), .ctrl_wr_en(wr), .ctrl_rd_en(rd),
    .ctrl_addr(addr), .ctrl_wdata(wdata), .ctrl_rdata(rdata), .crystal_osc_in(ph),
    .crystal_input_pin(ph & xi_run), .oscillator_start_bit(st), .on_backup_supply(bk),
    .trim_swallow(sw), .trim_insert(ins), .clock_out_pin(pin), .clock_out_oe_n(oe_n),
    .alarm_one_enable(a1), .alarm_zero_enable(a0), .external_osc_input(ext),
    .osc_tick(otk));
  always @(posedge otk) ticks++;
  cos_pin_load u_load (.clock_out_pin(pin), .clock_out_oe_n(oe_n), .line_level(line),
    .rise_count(rises));
  task automatic chk(input string n, input int lo, input int hi, input logic [7:0] got);
    n_compared++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      $display("[FAIL] %s exp %0d..%0d got %0d", n, lo, hi, got);
      fails++;
    end
  endtask
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(posedge clk) #1;
    wr = 1'b0;
  endtask
  task automatic rd8(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk) #1;
    rd = 1'b1;
    addr = a;
    @(posedge clk) #1;
    rd = 1'b0;
    chk("rdata", e, e, rdata);
  endtask
  // Rising edges over 64 oscillator periods
  task automatic meas(input logic [7:0] cfg, input int lo, input int hi);
    int c0;
    wr8(8'h08, cfg);
    repeat (40) @(posedge clk);
    c0 = rises;
    repeat (512) @(posedge clk);
    chk("edges", lo, hi, 8'(rises - c0));
  endtask
  task automatic t_reg;
    rd8(8'h08, 8'h80);
    wr8(8'h08, 8'h38);
    chk("ctrl", 7, 7, 8'({a1, a0, ext}));
    wr8(8'h09, 8'hff);
    rd8(8'h08, 8'h38);
    rd8(8'h09, 8'h00);
    $display("t_reg done");
  endtask
  task automatic t_gpo;
    wr8(8'h08, 8'h87);
    repeat (3) @(posedge clk);
    chk("pin", 1, 1, 8'(line));
    wr8(8'h08, 8'h03);
    repeat (3) @(posedge clk);
    chk("pin", 0, 0, 8'(line));
    $display("t_gpo done");
  endtask
  task automatic t_rates;
    meas(8'h41, 7, 9);
    meas(8'h42, 15, 17);
    meas(8'hc3, 63, 65);
    meas(8'h40, 0, 1);
    meas(8'h47, 0, 1);
    meas(8'h41, 7, 9);
    @(posedge clk) #1;
    sw = 1'b1;
    meas(8'h42, 0, 1);
    meas(8'h43, 63, 65);
    @(posedge clk) #1;
    sw = 1'b0;
    ins = 1'b1;
    meas(8'h42, 127, 129);
    @(posedge clk) #1;
    ins = 1'b0;
    $display("t_rates done");
  endtask
  task automatic t_ext;
    int k0;
    @(posedge clk) #1;
    st = 1'b0;
    xi_run = 1'b1;
    meas(8'h4b, 63, 65);
    k0 = ticks;
    repeat (512) @(posedge clk);
    chk("ticks", 63, 65, 8'(ticks - k0));
    meas(8'h43, 0, 0);
    k0 = ticks;
    repeat (512) @(posedge clk);
    chk("ticks", 0, 0, 8'(ticks - k0));
    @(posedge clk) #1;
    st = 1'b1;
    xi_run = 1'b0;
    $display("t_ext done");
  endtask
  task automatic t_bkp;
    wr8(8'h08, 8'h80);
    bk = 1'b1;
    repeat (4) @(posedge clk);
    chk("oe_n", 1, 1, 8'(oe_n));
    chk("line", 0, 0, 8'(line));
    #1 bk = 1'b0;
    repeat (4) @(posedge clk);
    chk("line", 1, 1, 8'(line));
    $display("t_bkp done");
  endtask
  // Reset in mid-run must restore the control value and release the pin
  task automatic t_rst;
    wr8(8'h08, 8'h7b);
    @(posedge clk) #1;
    rst = 1'b1;
    #1;
    chk("rst_oe_n", 1, 1, 8'(oe_n));
    chk("rst_ctrl", 0, 0, 8'({a1, a0, ext}));
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    rd8(8'h08, 8'h80);
    repeat (2) @(posedge clk);
    #1;
    chk("rst_line", 1, 1, 8'(line));
    $display("t_rst done");
  endtask
  task automatic end_sim;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    t_reg();
    t_gpo();
    t_rates();
    t_ext();
    t_bkp();
    t_rst();
    end_sim();
  end
  initial begin
    #300000;
    fails++;
    end_sim();
  end
endmodule
